// *** rtl/ltsc_pkg.sv ***
// Package for the latency tolerance state control block.
// Assumes one 250 MHz system clock and a synchronous active-high reset.
package ltsc_pkg;

  // Clock rate and the U0 return lead time ahead of the U2 inactivity timer.
  localparam int CLK_MHZ        = 250;
  localparam int U0_LEAD_NS     = 1000;
  localparam int U0_LEAD_CYCLES = (U0_LEAD_NS * CLK_MHZ + 999) / 1000;

  // BELT encoding width and design minimums, in microseconds.
  localparam int BELT_W         = 16;
  localparam int RELAXED_MIN_US = 1000;
  localparam int TIGHT_MIN_US   = 125;

  // Default endpoint count.
  localparam int NUM_EP = 8;

  // Link power states seen from the link layer.
  typedef enum logic [1:0] {
    LTSC_U0 = 2'h0,
    LTSC_U1 = 2'h1,
    LTSC_U2 = 2'h2,
    LTSC_U3 = 2'h3
  } ltsc_link_t;

  // Latency tolerance states, one-hot.
  typedef enum logic [1:0] {
    RELAXED_LATENCY_STATE = 2'b01,
    TIGHT_LATENCY_STATE   = 2'b10
  } ltsc_state_t;

  // Sequencer for the way down to U2 and the return to U0 before it.
  typedef enum logic [3:0] {
    SEQ_IDLE   = 4'b0001,
    SEQ_WAKE   = 4'b0010,
    SEQ_SEND   = 4'b0100,
    SEQ_ENTER  = 4'b1000
  } ltsc_seq_t;

  // Latency budgets supplied by the device configuration.
  typedef struct packed {
    logic [BELT_W-1:0] totalTolerance;
    logic [BELT_W-1:0] u1Sel;
    logic [BELT_W-1:0] u2Sel;
    logic [BELT_W-1:0] beltMin;
    logic [BELT_W-1:0] beltDefault;
  } ltsc_budget_t;

  // Outgoing LTM transaction packet request.
  typedef struct packed {
    logic              valid;
    logic [BELT_W-1:0] belt;
  } ltsc_ltm_t;

endpackage : ltsc_pkg

// *** rtl/ltsc_latency_ctrl.sv ***
// Latency tolerance state control: relaxed/tight tracking and LTM reporting.
// Assumes link-layer inputs synchronous to clk_sys and a link layer that takes
// LTM and ERDY requests with a ready handshake.
module ltsc_latency_ctrl
  import ltsc_pkg::*;
#(
  parameter int NumEp = ltsc_pkg::NUM_EP
) (
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  // Configuration
  input  wire ltsc_pkg::ltsc_budget_t         budget,
  input  wire logic [NumEp-1:0]               epIsoch,
  input  wire logic [NumEp-1:0][ltsc_pkg::BELT_W-1:0] epBelt,
  input  wire logic                           ltmEnable,
  // Transfer events
  input  wire logic                           bulkOutPending,
  input  wire logic                           inRequest,
  input  wire logic                           inServiceFits,
  input  wire logic                           localInData,
  input  wire logic                           controlXfer,
  // Link state and U2 timer
  input  wire ltsc_pkg::ltsc_link_t           linkState,
  input  wire logic                           u2Wanted,
  input  wire logic [15:0]                    u2TimerLeft,
  // Link layer requests
  output ltsc_pkg::ltsc_ltm_t                 ltmReq,
  input  wire logic                           ltmReady,
  output logic                                erdyReq,
  input  wire logic                           erdyReady,
  output logic                                wakeU0Req,
  output logic                                enterU2Req,
  // Status
  output logic                                tightState,
  output logic [ltsc_pkg::BELT_W-1:0]         reportedBelt
);
  import ltsc_pkg::*;

  initial begin
    if (NumEp < 1) $error("NumEp must be at least one.");
  end

  function automatic logic [BELT_W-1:0] satSub(input logic [BELT_W-1:0] a,
                                               input logic [BELT_W-1:0] b);
    satSub = (a > b) ? a - b : '0;
  endfunction

  function automatic logic [BELT_W-1:0] maxOf(input logic [BELT_W-1:0] a,
                                              input logic [BELT_W-1:0] b);
    maxOf = (a > b) ? a : b;
  endfunction

  // Endpoint aggregation: minimum across non-isochronous endpoints.
  logic [NumEp:0][BELT_W-1:0] epMinChain;
  assign epMinChain[0] = {BELT_W{1'b1}};
  for (genvar i = 0; i < NumEp; i++) begin : g_epMin
    assign epMinChain[i+1] = (!epIsoch[i] && epBelt[i] < epMinChain[i]) ?
                             epBelt[i] : epMinChain[i];
  end
  wire logic [BELT_W-1:0] epMin = epMinChain[NumEp];

  // Per-state BELT; floors bound the budget figure, but a lower endpoint minimum is held only to beltMin (tight) or beltDefault (relaxed).
  localparam logic [BELT_W-1:0] RelaxedFloor = BELT_W'(RELAXED_MIN_US);
  localparam logic [BELT_W-1:0] TightFloor   = BELT_W'(TIGHT_MIN_US);
  wire logic [BELT_W-1:0] relaxedRaw = satSub(budget.totalTolerance, budget.u2Sel);
  wire logic [BELT_W-1:0] tightRaw   = satSub(budget.totalTolerance, budget.u1Sel);
  wire logic [BELT_W-1:0] relaxedFloored =
      maxOf(maxOf(relaxedRaw, RelaxedFloor), budget.beltDefault);
  wire logic [BELT_W-1:0] tightFloored =
      maxOf(maxOf(tightRaw, TightFloor), budget.beltMin);
  wire logic [BELT_W-1:0] relaxedBelt = (epMin < relaxedFloored) ?
      maxOf(epMin, budget.beltDefault) : relaxedFloored;
  wire logic [BELT_W-1:0] tightBelt = (epMin < tightFloored) ?
      maxOf(epMin, budget.beltMin) : tightFloored;

  // State registers.
  ltsc_state_t state_q, state_d;
  ltsc_seq_t   seq_q, seq_d;
  logic        pendLtm_q, pendLtm_d;
  logic        pendErdy_q, pendErdy_d;
  logic        ltmEnable_q;
  logic        ltmEnable_d;
  logic [BELT_W-1:0] belt_q, belt_d;

  // Tight entry triggers; control transfers are deliberately not among them.
  wire logic inFits      = inRequest && inServiceFits;
  wire logic goTight     = bulkOutPending || inFits || localInData;
  wire logic isRelaxed   = (state_q == RELAXED_LATENCY_STATE);
  wire logic enterTight  = isRelaxed && goTight && (seq_q == SEQ_IDLE);
  wire logic nearExpiry  = (u2TimerLeft <= 16'(U0_LEAD_CYCLES));
  wire logic u2Prep      = !isRelaxed && u2Wanted && nearExpiry && (seq_q == SEQ_IDLE);
  wire logic ltmRising   = ltmEnable && !ltmEnable_q;
  wire logic ltmTaken    = ltmReq.valid && ltmReady;
  // The disable is held off inside until the final LTM is accepted; a request
  // already waiting at the disable serves as that final one.
  wire logic ltmFalling  = !ltmEnable && ltmEnable_q && !pendLtm_q;

  always_comb begin
    state_d    = state_q;
    seq_d      = seq_q;
    belt_d     = belt_q;
    pendLtm_d  = pendLtm_q && !ltmTaken;
    pendErdy_d = pendErdy_q && !(erdyReq && erdyReady);
    if (enterTight) begin
      state_d   = TIGHT_LATENCY_STATE;
      belt_d    = tightBelt;
      pendLtm_d = 1'b1;
      if (localInData) begin
        pendErdy_d = 1'b1;
      end
    end
    unique case (seq_q)
      SEQ_IDLE: begin
        if (u2Prep) begin
          seq_d = (linkState == LTSC_U0) ? SEQ_SEND : SEQ_WAKE;
          if (linkState == LTSC_U0) begin
            state_d   = RELAXED_LATENCY_STATE;
            belt_d    = relaxedBelt;
            pendLtm_d = 1'b1;
          end
        end
      end
      SEQ_WAKE: begin
        if (linkState == LTSC_U0) begin
          state_d   = RELAXED_LATENCY_STATE;
          belt_d    = relaxedBelt;
          pendLtm_d = 1'b1;
          seq_d     = SEQ_SEND;
        end
      end
      SEQ_SEND: begin
        if (!pendLtm_d || !ltmEnable) begin
          seq_d = SEQ_ENTER;
        end
      end
      SEQ_ENTER: begin
        seq_d = SEQ_IDLE;
      end
      default: seq_d = SEQ_IDLE;
    endcase
    if (ltmRising || ltmFalling) begin
      pendLtm_d = 1'b1;
      belt_d    = isRelaxed ? relaxedBelt : tightBelt;
    end
    if (!ltmEnable && !ltmEnable_q) begin
      pendLtm_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q     <= RELAXED_LATENCY_STATE;
      seq_q       <= SEQ_IDLE;
      belt_q      <= '0;
      pendLtm_q   <= 1'b0;
      pendErdy_q  <= 1'b0;
      ltmEnable_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      seq_q       <= seq_d;
      belt_q      <= belt_d;
      pendLtm_q   <= pendLtm_d;
      pendErdy_q  <= pendErdy_d;
      ltmEnable_q <= ltmEnable_d;
    end
  end

  // Enable is tracked so the final packet before disable still goes out.
  assign ltmEnable_d = ltmEnable || (ltmEnable_q && pendLtm_d);

  // Outputs.
  assign ltmReq.valid = pendLtm_q && ltmEnable_q;
  assign ltmReq.belt  = belt_q;
  assign erdyReq      = pendErdy_q;
  assign wakeU0Req    = (seq_q == SEQ_WAKE) ||
                        (pendErdy_q && linkState != LTSC_U0);
  assign enterU2Req   = (seq_q == SEQ_ENTER);
  assign tightState   = (state_q == TIGHT_LATENCY_STATE);
  assign reportedBelt = belt_q;

endmodule // ltsc_latency_ctrl

// *** tb/ltsc_assertions.sv ***
// Port checker for the latency tolerance control block.
// Assumes it is bound onto ltsc_latency_ctrl, one clock domain.
module ltsc_assertions
  import ltsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Inputs
  input wire ltsc_pkg::ltsc_budget_t budget,
  input wire logic ltmEnable,
  input wire logic bulkOutPending,
  input wire logic inRequest,
  input wire logic localInData,
  input wire logic controlXfer,
  input wire ltsc_pkg::ltsc_link_t linkState,
  input wire logic u2Wanted,
  input wire logic [15:0] u2TimerLeft,
  input wire logic ltmReady,
  // Outputs
  input wire ltsc_pkg::ltsc_ltm_t ltmReq,
  input wire logic erdyReq,
  input wire logic wakeU0Req,
  input wire logic enterU2Req,
  input wire logic tightState,
  input wire logic [ltsc_pkg::BELT_W-1:0] reportedBelt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence relax_s;
    $fell(tightState) && ltmEnable;
  endsequence
  property relax_first_p;
    relax_s |-> ltmReq.valid && !enterU2Req;
  endproperty
  reset_relaxed_a: assert property (disable iff (1'b0)
    rst |=> !tightState && !ltmReq.valid) else $error("not relaxed after reset");
  change_sends_a: assert property (
    ltmEnable && $changed(tightState) |-> ltmReq.valid) else $error("no LTM on change");
  ltm_holds_a: assert property (
    ltmReq.valid && !ltmReady |=> ltmReq.valid && $stable(ltmReq.belt)) else $error("LTM dropped");
  tight_floor_a: assert property (
    $rose(tightState) |-> reportedBelt >= budget.beltMin && reportedBelt >= 16'h007D)
    else $error("tight BELT too small");
  erdy_local_a: assert property (
    !tightState && localInData && !ltmReq.valid && !u2Wanted |=> tightState && erdyReq)
    else $error("local data ignored");
  control_kept_a: assert property (
    !tightState && controlXfer && !localInData && !bulkOutPending && !inRequest |=> !tightState)
    else $error("control changed state");
  relax_first_a: assert property (relax_first_p) else $error("U2 before relax LTM");
  u2_from_u0_a: assert property (
    enterU2Req |-> !tightState && linkState == LTSC_U0) else $error("bad U2 entry");
  wake_lead_a: assert property (
    tightState && linkState == LTSC_U1 && u2Wanted && u2TimerLeft <= 16'h00FA |-> ##[0:2] wakeU0Req)
    else $error("no early wake");
  silent_off_a: assert property (
    $rose(ltmReq.valid) |-> ltmEnable || $past(ltmEnable) || $past(ltmEnable, 2))
    else $error("LTM while disabled");
endmodule // ltsc_assertions

bind ltsc_latency_ctrl ltsc_assertions chk_i (.clk_sys, .rst, .budget, .ltmEnable,
  .bulkOutPending, .inRequest, .localInData, .controlXfer, .linkState, .u2Wanted,
  .u2TimerLeft, .ltmReady, .ltmReq, .erdyReq, .wakeU0Req, .enterU2Req, .tightState,
  .reportedBelt);

// *** tb/ltsc_link_model.sv ***
// Link layer model: takes LTM and ERDY requests and tracks link state.
// Assumes the bench steers the link state through linkSet and linkSetEn.
module ltsc_link_model
  import ltsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Requests from the block
  input wire ltsc_pkg::ltsc_ltm_t ltmReq,
  input wire logic erdyReq,
  input wire logic wakeU0Req,
  input wire logic enterU2Req,
  // Bench control
  input wire logic slow,
  input wire logic linkSetEn,
  input wire ltsc_pkg::ltsc_link_t linkSet,
  // Answers
  output logic ltmReady,
  output logic erdyReady,
  output ltsc_pkg::ltsc_link_t linkState,
  output int ltmCount,
  output logic [ltsc_pkg::BELT_W-1:0] ltmBelt
);
  int waitQ;
  // A slow accept shows whether the block holds its request steady.
  assign ltmReady = ltmReq.valid && waitQ >= (slow ? 4 : 1);
  assign erdyReady = erdyReq;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      waitQ <= 0;
      ltmCount <= 0;
      linkState <= LTSC_U0;
    end else begin
      waitQ <= (ltmReq.valid && !ltmReady) ? waitQ + 1 : 0;
      if (ltmReq.valid && ltmReady) begin
        ltmCount <= ltmCount + 1;
        ltmBelt <= ltmReq.belt;
      end
      if (linkSetEn) linkState <= linkSet;
      else if (enterU2Req) linkState <= LTSC_U2;
      else if (wakeU0Req) linkState <= LTSC_U0;
    end
  end
endmodule // ltsc_link_model

// *** tb/tb.sv ***
// Bench for the latency tolerance control block and a link layer model.
// Assumes the block's hand-over timing and a 250 MHz clock.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ltsc_pkg::*;
  logic clk_sys = 0, rst = 1, ltmEnable = 1, bulkOutPending = 0, inRequest = 0;
  logic inServiceFits = 0, localInData = 0, controlXfer = 0, u2Wanted = 0, slow = 0;
  logic linkSetEn = 0, erdyReq, erdyReady, wakeU0Req, enterU2Req, tightState, ltmReady;
  logic [15:0] u2TimerLeft = 16'h1000, reportedBelt, ltmBelt, tight;
  logic [3:0] epIsoch = 4'h0;
  logic [3:0][15:0] epBelt = '1;
  ltsc_budget_t bud = '{16'h07D0, 16'h0064, 16'h01F4, 16'h00C8, 16'h044C};
  ltsc_link_t linkState, linkSet = LTSC_U0;
  ltsc_ltm_t ltmReq;
  int failures = 0, cmpCount = 0, ltmCount;
  assign tight = bud.totalTolerance - bud.u1Sel;
  ltsc_latency_ctrl #(.NumEp(4)) uut (.clk_sys, .rst, .budget(bud), .epIsoch, .epBelt,
    .ltmEnable, .bulkOutPending, .inRequest, .inServiceFits, .localInData, .controlXfer,
    .linkState, .u2Wanted, .u2TimerLeft, .ltmReq, .ltmReady, .erdyReq, .erdyReady,
    .wakeU0Req, .enterU2Req, .tightState, .reportedBelt);
  ltsc_link_model link (.clk_sys, .rst, .ltmReq, .erdyReq, .wakeU0Req, .enterU2Req, .slow,
    .linkSetEn, .linkSet, .ltmReady, .erdyReady, .linkState, .ltmCount, .ltmBelt);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic drain();
    for (int i = 0; i < 20 && (ltmReq.valid || erdyReq); i++) tick();
  endtask
  task automatic setLink(ltsc_link_t s);
    linkSetEn = 1;
    linkSet = s;
    tick();
    linkSetEn = 0;
  endtask
  task automatic tBulk(logic [15:0] exp);
    int n;
    n = ltmCount;
    bulkOutPending = 1;
    tick();
    bulkOutPending = 0;
    chk(tightState, 1);
    chk(ltmReq.valid, ltmEnable);
    if (ltmEnable) chk(ltmReq.belt, exp);
    drain();
    tick(2);
    chk(16'(ltmCount - n), ltmEnable);
  endtask
  task automatic tRelax(ltsc_link_t from);
    int n;
    n = ltmCount;
    setLink(from);
    u2Wanted = 1;
    u2TimerLeft = 16'h00FA;
    for (int i = 0; i < 60 && !enterU2Req; i++) tick();
    chk(enterU2Req, 1);
    chk(tightState, 0);
    chk(linkState, LTSC_U0);
    chk(ltmBelt, bud.totalTolerance - bud.u2Sel);
    chk(16'(ltmCount - n), 1);
    u2Wanted = 0;
    u2TimerLeft = 16'h1000;
    tick();
    setLink(LTSC_U0);
  endtask
  task automatic tSide();
    controlXfer = 1;
    tick(3);
    controlXfer = 0;
    chk(tightState, 0);
    setLink(LTSC_U1);
    localInData = 1;
    tick();
    localInData = 0;
    chk({tightState, erdyReq, wakeU0Req}, 3'h7);
    drain();
  endtask
  task automatic tIn();
    inRequest = 1;
    tick(3);
    chk(tightState, 0);
    inServiceFits = 1;
    tick();
    inRequest = 0;
    inServiceFits = 0;
    chk(tightState, 1);
    drain();
  endtask
  task automatic tToggle();
    ltmEnable = 0;
    for (int i = 0; i < 5 && !ltmReq.valid; i++) tick();
    chk(ltmReq.valid, 1);
    drain();
    tBulk(tight);
    ltmEnable = 1;
    for (int i = 0; i < 5 && !ltmReq.valid; i++) tick();
    chk(ltmReq.belt, tight);
    drain();
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #40000;
    failures++;
    summarize();
  end
  initial begin
    tick(4);
    rst = 0;
    chk({tightState, reportedBelt}, 16'h0000);
    tSide();
    tRelax(LTSC_U1);
    slow = 1;
    tBulk(tight);
    slow = 0;
    tRelax(LTSC_U0);
    tIn();
    tRelax(LTSC_U0);
    epIsoch = 4'h1;
    epBelt[0] = 16'h0064;
    epBelt[2] = 16'h012C;
    tBulk(16'h012C);
    epBelt = '1;
    tRelax(LTSC_U0);
    tToggle();
    tRelax(LTSC_U0);
    summarize();
  end
endmodule // tb
